/* verification/psfs_checker.sv */
/*
  Temporal checks on the fault supervisor ports.
  Assumes one clock domain and the asynchronous high reset of psfs_top.
*/
`timescale 1ns/1ns

module psfs_checker (
  // Clock, reset and bus
  input wire logic       MCLK_I,
  input wire logic       SYS_RST_I,
  input wire logic       WB_ACK_O,
  input wire logic       WB_STB_I,
  // Sensors and command
  input wire logic       SW_OT_TRIP_I,
  input wire logic       DRV_OT_TRIP_I,
  input wire logic       DRV_OT_FALL_I,
  input wire logic       SUPPLY_LOCKOUT_I,
  input wire logic       OC_DETECT_I,
  input wire logic       SC_DETECT_I,
  input wire logic       SWITCH_CMD_I,
  // Stage and report outputs
  input wire logic       GATE_ON_O,
  input wire logic       HOT_DE_EN_O,
  input wire logic       AUX_REG_EN_O,
  input wire logic       NEG_RAIL_EN_O,
  input wire logic       FAULT_N_O,
  input wire logic       OC_FLAG_N_O,
  input wire logic       TEMP_PWM_O
);
  default clocking cb @(posedge MCLK_I);
  endclocking
  default disable iff (SYS_RST_I);

  a_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("bus ack longer than one cycle");
  a_drv_ot_off: assert property (
    DRV_OT_TRIP_I |=> ##1 (!AUX_REG_EN_O && !NEG_RAIL_EN_O && !GATE_ON_O && !HOT_DE_EN_O))
    else $error("driver over-temperature left the stage running");
  a_sw_ot_diode: assert property (
    (SW_OT_TRIP_I && DRV_OT_FALL_I && !DRV_OT_TRIP_I && !SUPPLY_LOCKOUT_I)
      |=> ##1 (HOT_DE_EN_O && !GATE_ON_O))
    else $error("switch over-temperature did not enter diode emulation");
  a_ot_fault_low: assert property ((SW_OT_TRIP_I || DRV_OT_TRIP_I) |=> ##1 !FAULT_N_O)
    else $error("fault output high during thermal shutdown");
  a_ot_temp_high: assert property ((SW_OT_TRIP_I || DRV_OT_TRIP_I) |=> ##1 TEMP_PWM_O)
    else $error("thermal output not forced high");
  a_fault_release: assert property (
    $rose(FAULT_N_O) |-> (!$past(SW_OT_TRIP_I, 2) && !$past(DRV_OT_TRIP_I, 2)))
    else $error("fault released while a sensor still tripped");
  a_lockout_off: assert property (
    SUPPLY_LOCKOUT_I |=> ##1 (!FAULT_N_O && !GATE_ON_O))
    else $error("lockout did not hold the switch off");
  a_flag_low: assert property ((OC_DETECT_I || SC_DETECT_I) |=> ##1 !OC_FLAG_N_O)
    else $error("current flag not driven low");
  a_short_hold: assert property (
    SC_DETECT_I ##1 (!SC_DETECT_I && SWITCH_CMD_I && !SUPPLY_LOCKOUT_I && !WB_STB_I)[*4]
      |=> ##1 (!FAULT_N_O && !OC_FLAG_N_O))
    else $error("short latch released while command high");
endmodule

bind psfs_top psfs_checker i_chk (
  .MCLK_I(MCLK_I), .SYS_RST_I(SYS_RST_I), .WB_ACK_O(WB_ACK_O), .WB_STB_I(WB_STB_I),
  .SW_OT_TRIP_I(SW_OT_TRIP_I), .DRV_OT_TRIP_I(DRV_OT_TRIP_I), .DRV_OT_FALL_I(DRV_OT_FALL_I),
  .SUPPLY_LOCKOUT_I(SUPPLY_LOCKOUT_I), .OC_DETECT_I(OC_DETECT_I), .SC_DETECT_I(SC_DETECT_I),
  .SWITCH_CMD_I(SWITCH_CMD_I), .GATE_ON_O(GATE_ON_O), .HOT_DE_EN_O(HOT_DE_EN_O),
  .AUX_REG_EN_O(AUX_REG_EN_O), .NEG_RAIL_EN_O(NEG_RAIL_EN_O), .FAULT_N_O(FAULT_N_O),
  .OC_FLAG_N_O(OC_FLAG_N_O), .TEMP_PWM_O(TEMP_PWM_O)
);

/* verification/psfs_ctrl_model.sv */
/*
  Controller side: drives the switch command and resolves the flag wire.
  Assumes the bench chooses the command and whether the flag pin is strapped.
*/
`timescale 1ns/1ns

module psfs_ctrl_model (
  // Bench choices
  input  wire logic cmd_req_i,
  input  wire logic flag_tied_i,
  // Device flag pin
  input  wire logic flag_n_i,
  input  wire logic flag_oe_i,
  // To device and bench
  output logic      switch_cmd_o,
  output logic      flag_pin_o,
  output logic      flag_seen_o
);
  assign switch_cmd_o = cmd_req_i;
  // Strap wins, else the driver, else the board pull-up
  assign flag_pin_o = flag_tied_i ? 1'b0 : (flag_oe_i ? flag_n_i : 1'b1);
  assign flag_seen_o = !flag_tied_i && (flag_pin_o === 1'b0);
endmodule

/* verification/tb_psfs_top.sv */
/*
  Self-checking bench for psfs_top with a classic Wishbone master.
  Assumes shortened counts: PWM period 100, slew filter 8, short reset 4.
*/
`timescale 1ns/1ns

module tb_psfs_top;
  localparam int PWM_P = 100;
  logic        clk, rst, cyc, stb, we, ack;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat, q;
  logic        sw_trip, sw_fall, drv_trip, drv_fall, lock, ser_on, ovc, sc, cmd_req;
  logic        s_gnd, s_rail, s_open, tied, sw_cmd, flag_pin, flag_seen;
  logic [7:0]  s_vns, temp, slew;
  logic        gate, hot_de, aux, neg, fault_n, flag_n, flag_oe, temp_pwm;
  int          errors, total_checks;
  int          i_t[4] = '{20, 25, 150, 175};

  psfs_top #(.PWM_PERIOD_CYC(PWM_P), .SLEW_FILT_CYC(8), .SC_RESET_CYC(4)) i_dut (
    .MCLK_I(clk), .SYS_RST_I(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
    .SW_OT_TRIP_I(sw_trip), .SW_OT_FALL_I(sw_fall), .DRV_OT_TRIP_I(drv_trip),
    .DRV_OT_FALL_I(drv_fall), .SUPPLY_LOCKOUT_I(lock), .SERIES_SW_ON_I(ser_on),
    .OC_DETECT_I(ovc), .SC_DETECT_I(sc), .DIE_TEMP_C_I(temp), .SWITCH_CMD_I(sw_cmd),
    .SLEW_PIN_GND_I(s_gnd), .SLEW_PIN_RAIL_I(s_rail), .SLEW_PIN_OPEN_I(s_open),
    .SLEW_RES_VNS_I(s_vns), .OC_FLAG_PIN_I(flag_pin), .GATE_ON_O(gate),
    .HOT_DE_EN_O(hot_de), .AUX_REG_EN_O(aux), .NEG_RAIL_EN_O(neg), .SLEW_RATE_O(slew),
    .FAULT_N_O(fault_n), .OC_FLAG_N_O(flag_n), .OC_FLAG_OE_O(flag_oe), .TEMP_PWM_O(temp_pwm)
  );

  psfs_ctrl_model i_ctrl (
    .cmd_req_i(cmd_req), .flag_tied_i(tied), .flag_n_i(flag_n), .flag_oe_i(flag_oe),
    .switch_cmd_o(sw_cmd), .flag_pin_o(flag_pin), .flag_seen_o(flag_seen)
  );

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      errors++;
    end
  endtask

  task automatic pair(input logic f, input logic o);
    chk("fault_n", {31'h0, f}, {31'h0, fault_n});
    chk("flag_n", {31'h0, o}, {31'h0, flag_n});
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Holds the request until ack is sampled, then idles one cycle
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hF;
    wdat <= d;
    do
      @(posedge clk);
    while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk);
  endtask

  function automatic int duty_hi(input int t);
    int pm;
    pm = (t < 25) ? 10 : 30 + (t - 25) * 790 / 125;
    if (pm > 1000)
      pm = 1000;
    return pm * PWM_P / 1000;
  endfunction

  task automatic lvl(input logic v, inout int n);
    do
    begin
      @(posedge clk);
      n++;
    end
    while (temp_pwm !== v);
  endtask

  task automatic pwm_chk(input int t);
    int hi;
    int per;
    hi = 0;
    per = 0;
    temp <= t[7:0];
    wt(250);
    repeat (PWM_P)
    begin
      @(posedge clk);
      hi += (temp_pwm === 1'b1);
    end
    chk("pwm_high", duty_hi(t), hi);
    lvl(1'b0, per);
    lvl(1'b1, per);
    per = 0;
    lvl(1'b0, per);
    lvl(1'b1, per);
    chk("pwm_period", PWM_P, per);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rst = 1'b1;
    {cyc, stb, we, adr, sel, wdat} = '0;
    {sw_trip, sw_fall, drv_trip, drv_fall, lock, ser_on, ovc, sc, cmd_req} = '0;
    {s_rail, s_open, tied, s_vns} = '0;
    s_gnd = 1'b1;
    temp = 8'h30;
    wt(5);
    pair(1'b0, 1'b1);
    rst <= 1'b0;
    wt(20);
    pair(1'b0, 1'b1);
    ser_on <= 1'b1;
    cmd_req <= 1'b1;
    wt(15);
    pair(1'b1, 1'b1);
    chk("flag_oe", 32'h1, {31'h0, flag_oe});
    chk("slew", 32'h96, {24'h0, slew});
    chk("gate", 32'h1, {31'h0, gate});
    chk("rails", 32'h3, {30'h0, aux, neg});
    bus(1'b0, 8'h00, 32'h0);
    chk("ctrl", 32'h2, q);
    bus(1'b0, 8'h10, 32'h0);
    chk("unmapped", 32'h0, q);
    bus(1'b0, 8'h0C, 32'h0);
    chk("therm_temp", 32'h30, {24'h0, q[17:10]});
    // resistor setting changed in one step, then held well beyond the filter span
    s_gnd <= 1'b0;
    s_vns <= 8'h3C;
    wt(20);
    chk("slew", 32'h3C, {24'h0, slew});
    bus(1'b0, 8'h08, 32'h0);
    chk("slew_reg", 32'h23C, q);
    s_open <= 1'b1;
    wt(20);
    pair(1'b0, 1'b1);
    s_open <= 1'b0;
    s_gnd <= 1'b1;
    wt(20);
    pair(1'b1, 1'b1);
    ovc <= 1'b1;
    wt(1);
    ovc <= 1'b0;
    wt(3);
    pair(1'b1, 1'b0);
    cmd_req <= 1'b0;
    wt(3);
    pair(1'b1, 1'b1);
    cmd_req <= 1'b1;
    sc <= 1'b1;
    wt(1);
    sc <= 1'b0;
    wt(3);
    pair(1'b0, 1'b0);
    chk("gate", 32'h0, {31'h0, gate});
    wt(10);
    pair(1'b0, 1'b0);
    cmd_req <= 1'b0;
    wt(10);
    pair(1'b1, 1'b1);
    cmd_req <= 1'b1;
    sc <= 1'b1;
    wt(1);
    sc <= 1'b0;
    wt(2);
    bus(1'b1, 8'h00, 32'h3);
    wt(3);
    pair(1'b1, 1'b1);
    sw_trip <= 1'b1;
    wt(3);
    pair(1'b0, 1'b1);
    chk("hot_de", 32'h1, {31'h0, hot_de});
    chk("gate", 32'h0, {31'h0, gate});
    chk("temp_pwm", 32'h1, {31'h0, temp_pwm});
    drv_trip <= 1'b1;
    wt(3);
    chk("rails", 32'h0, {30'h0, aux, neg});
    chk("hot_de", 32'h0, {31'h0, hot_de});
    drv_trip <= 1'b0;
    drv_fall <= 1'b1;
    wt(3);
    chk("hot_de", 32'h1, {31'h0, hot_de});
    chk("rails", 32'h3, {30'h0, aux, neg});
    pair(1'b0, 1'b1);
    sw_trip <= 1'b0;
    wt(3);
    pair(1'b0, 1'b1);
    chk("temp_pwm", 32'h1, {31'h0, temp_pwm});
    sw_fall <= 1'b1;
    wt(3);
    pair(1'b1, 1'b1);
    chk("hot_de", 32'h0, {31'h0, hot_de});
    {sw_fall, drv_fall} <= 2'b00;
    lock <= 1'b1;
    wt(3);
    pair(1'b0, 1'b1);
    chk("gate", 32'h0, {31'h0, gate});
    bus(1'b0, 8'h04, 32'h0);
    chk("status", 32'hA0, q);
    lock <= 1'b0;
    wt(20);
    pair(1'b1, 1'b1);
    foreach (i_t[k])
      pwm_chk(i_t[k]);
    rst <= 1'b1;
    s_gnd <= 1'b0;
    s_rail <= 1'b1;
    tied <= 1'b1;
    wt(5);
    rst <= 1'b0;
    wt(20);
    chk("slew", 32'h64, {24'h0, slew});
    chk("flag_oe", 32'h0, {31'h0, flag_oe});
    s_rail <= 1'b0;
    s_vns <= 8'h3C;
    wt(20);
    chk("slew", 32'h64, {24'h0, slew});
    ovc <= 1'b1;
    wt(3);
    chk("fault_n", 32'h0, {31'h0, fault_n});
    chk("flag_seen", 32'h0, {31'h0, flag_seen});
    final_report();
  end

  initial
  begin
    wt(20000);
    errors++;
    final_report();
  end
endmodule

/* verilog/psfs_pkg.sv */
/*
  Types of the power stage fault supervisor. Needs nothing else.
*/
package psfs_pkg;

  // Where the slew setting comes from
  typedef enum logic [1:0] {
    SLEW_GND,
    SLEW_RAIL,
    SLEW_RES,
    SLEW_OPEN
  } psfs_slew_e;

  // Gate control mode handed to the driver
  typedef enum logic [1:0] {
    GATE_FOLLOW,
    GATE_HOT_DE,
    GATE_OFF
  } psfs_gate_e;

  // Fault state, also the status register layout
  typedef struct packed {
    logic startup;
    logic slew_open;
    logic lockout;
    logic drv_ot;
    logic sw_ot;
    logic overcurrent;
    logic short_circ;
    logic combined;
  } psfs_fault_s;

endpackage

/* verilog/psfs_regs.svh */
/*
  Register offsets, field positions, reset values and timing figures of the
  power stage fault supervisor. Assumes a 100 MHz system clock.
*/
`ifndef PSFS_REGS_SVH
`define PSFS_REGS_SVH

`define PSFS_CTRL_OFS      8'h00
`define PSFS_STATUS_OFS    8'h04
`define PSFS_SLEW_OFS      8'h08
`define PSFS_THERM_OFS     8'h0C

`define PSFS_CTRL_SC_CLR   0
`define PSFS_CTRL_PWM_EN   1
`define PSFS_CTRL_RST      32'h0000_0002

`define PSFS_CLK_MHZ       100
`define PSFS_CLK_HZ        100000000
`define PSFS_PWM_HZ        9000
`define PSFS_SC_RESET_NS   1000
`define PSFS_SLEW_FILT_US  100

`define PSFS_SLEW_GND_VNS  150
`define PSFS_SLEW_RAIL_VNS 100
`define PSFS_SLEW_MIN_VNS  30
`define PSFS_SLEW_MAX_VNS  150

`define PSFS_TEMP_LO_C     25
`define PSFS_TEMP_HI_C     150
`define PSFS_DUTY_MIN_PM   10
`define PSFS_DUTY_LO_PM    30
`define PSFS_DUTY_HI_PM    820
`define PSFS_DUTY_FULL_PM  1000

`endif

/* verilog/psfs_top.sv */
/*
  Power stage fault supervisor: thermal shutdown, supply lockout, two-wire
  fault report, slew select and thermal PWM, with a classic Wishbone slave.
  Assumes analog comparators and sensors arrive as synchronous levels.
*/
`timescale 1ns/1ns
`include "psfs_regs.svh"

module psfs_top #(
  parameter int PWM_PERIOD_CYC = `PSFS_CLK_HZ / `PSFS_PWM_HZ,
  parameter int SLEW_FILT_CYC  = `PSFS_SLEW_FILT_US * `PSFS_CLK_MHZ,
  parameter int SC_RESET_CYC   = (`PSFS_SC_RESET_NS * `PSFS_CLK_MHZ + 999) / 1000
) (
  // Clock and reset
  input  wire logic        MCLK_I,
  input  wire logic        SYS_RST_I,
  // Wishbone slave
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  // Sensors and comparators
  input  wire logic        SW_OT_TRIP_I,
  input  wire logic        SW_OT_FALL_I,
  input  wire logic        DRV_OT_TRIP_I,
  input  wire logic        DRV_OT_FALL_I,
  input  wire logic        SUPPLY_LOCKOUT_I,
  input  wire logic        SERIES_SW_ON_I,
  input  wire logic        OC_DETECT_I,
  input  wire logic        SC_DETECT_I,
  input  wire logic [7:0]  DIE_TEMP_C_I,
  // Switch command from the controller
  input  wire logic        SWITCH_CMD_I,
  // Slew select pin sense
  input  wire logic        SLEW_PIN_GND_I,
  input  wire logic        SLEW_PIN_RAIL_I,
  input  wire logic        SLEW_PIN_OPEN_I,
  input  wire logic [7:0]  SLEW_RES_VNS_I,
  // Flag pin level seen at power-up
  input  wire logic        OC_FLAG_PIN_I,
  // Power stage control
  output logic             GATE_ON_O,
  output logic             HOT_DE_EN_O,
  output logic             AUX_REG_EN_O,
  output logic             NEG_RAIL_EN_O,
  output logic      [7:0]  SLEW_RATE_O,
  // Fault report and thermal output
  output logic             FAULT_N_O,
  output logic             OC_FLAG_N_O,
  output logic             OC_FLAG_OE_O,
  output logic             TEMP_PWM_O
);

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  function automatic logic [9:0] duty_pm(input logic [7:0] temp);
    int d;
    d = `PSFS_DUTY_MIN_PM;
    if (temp >= 8'(`PSFS_TEMP_LO_C))
    begin
      d = `PSFS_DUTY_LO_PM + ((int'(temp) - `PSFS_TEMP_LO_C)
          * (`PSFS_DUTY_HI_PM - `PSFS_DUTY_LO_PM))
          / (`PSFS_TEMP_HI_C - `PSFS_TEMP_LO_C);
    end
    if (d > `PSFS_DUTY_FULL_PM)
    begin
      d = `PSFS_DUTY_FULL_PM;
    end
    return 10'(d);
  endfunction

  function automatic logic [7:0] clamp_slew(input logic [7:0] vns);
    logic [7:0] r;
    r = vns;
    if (vns < 8'(`PSFS_SLEW_MIN_VNS))
    begin
      r = 8'(`PSFS_SLEW_MIN_VNS);
    end
    if (vns > 8'(`PSFS_SLEW_MAX_VNS))
    begin
      r = 8'(`PSFS_SLEW_MAX_VNS);
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone slave

  logic        ack_q;
  logic        req;
  logic        wr_take;
  logic        pwm_en_q;
  logic        sc_clr_q;
  logic [31:0] rd_d;
  logic [31:0] rd_q;

  psfs_pkg::psfs_fault_s fault_q;
  psfs_pkg::psfs_slew_e  slew_src_q;
  logic [9:0]            duty_q;

  assign req     = WB_CYC_I & WB_STB_I;
  // Write commits on the edge where the master sees ack
  assign wr_take = req & WB_WE_I & ack_q & WB_SEL_I[0] & (WB_ADR_I == `PSFS_CTRL_OFS);

  always_comb
  begin
    rd_d = 32'h0000_0000;
    unique case (WB_ADR_I)
      `PSFS_CTRL_OFS:   rd_d[`PSFS_CTRL_PWM_EN] = pwm_en_q;
      `PSFS_STATUS_OFS: rd_d[7:0] = fault_q;
      `PSFS_SLEW_OFS:   rd_d[9:0] = {slew_src_q, SLEW_RATE_O};
      `PSFS_THERM_OFS:  rd_d[17:0] = {DIE_TEMP_C_I, duty_q};
      default:          rd_d = 32'h0000_0000;
    endcase
  end

  // One wait state, ack drops the cycle after it is given
  always_ff @(posedge MCLK_I or posedge SYS_RST_I)
  begin
    if (SYS_RST_I)
    begin
      ack_q <= 1'b0;
      rd_q  <= 32'h0000_0000;
    end
    else
    begin
      ack_q <= req & ~ack_q;
      rd_q  <= rd_d;
    end
  end

  assign WB_ACK_O = ack_q;
  assign WB_DAT_O = rd_q;

  always_ff @(posedge MCLK_I or posedge SYS_RST_I)
  begin
    if (SYS_RST_I)
    begin
      pwm_en_q <= 1'(`PSFS_CTRL_RST >> `PSFS_CTRL_PWM_EN);
      sc_clr_q <= 1'b0;
    end
    else
    begin
      sc_clr_q <= wr_take & WB_DAT_I[`PSFS_CTRL_SC_CLR];
      if (wr_take)
      begin
        pwm_en_q <= WB_DAT_I[`PSFS_CTRL_PWM_EN];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power-up capture

  logic boot_q;
  logic combined_q;
  logic rail_tie_q;

  always_ff @(posedge MCLK_I or posedge SYS_RST_I)
  begin
    if (SYS_RST_I)
    begin
      boot_q     <= 1'b1;
      combined_q <= 1'b0;
      rail_tie_q <= 1'b0;
    end
    else if (boot_q)
    begin
      boot_q     <= 1'b0;
      combined_q <= ~OC_FLAG_PIN_I;
      rail_tie_q <= SLEW_PIN_RAIL_I;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Thermal shutdown with hysteresis

  logic sw_ot_q;
  logic drv_ot_q;

  always_ff @(posedge MCLK_I or posedge SYS_RST_I)
  begin
    if (SYS_RST_I)
    begin
      sw_ot_q  <= 1'b0;
      drv_ot_q <= 1'b0;
    end
    else
    begin
      if (SW_OT_TRIP_I)
        sw_ot_q <= 1'b1;
      else if (SW_OT_FALL_I)
        sw_ot_q <= 1'b0;
      if (DRV_OT_TRIP_I)
        drv_ot_q <= 1'b1;
      else if (DRV_OT_FALL_I)
        drv_ot_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Current faults

  logic        oc_q;
  logic        sc_q;
  logic [15:0] cmd_low_q;
  logic        cmd_low_done;

  assign cmd_low_done = (cmd_low_q >= 16'(SC_RESET_CYC));

  always_ff @(posedge MCLK_I or posedge SYS_RST_I)
  begin
    if (SYS_RST_I)
      cmd_low_q <= 16'h0000;
    else if (SWITCH_CMD_I)
      cmd_low_q <= 16'h0000;
    else if (!cmd_low_done)
      cmd_low_q <= cmd_low_q + 16'h0001;
  end

  always_ff @(posedge MCLK_I or posedge SYS_RST_I)
  begin
    if (SYS_RST_I)
    begin
      oc_q <= 1'b0;
      sc_q <= 1'b0;
    end
    else
    begin
      // Cycle by cycle: held until the command goes low; detect wins
      if (OC_DETECT_I)
        oc_q <= 1'b1;
      else if (!SWITCH_CMD_I)
        oc_q <= 1'b0;
      // latch clears on long low command, supply loss or bus clear
      if (SC_DETECT_I)
        sc_q <= 1'b1;
      else if (cmd_low_done || SUPPLY_LOCKOUT_I || sc_clr_q)
        sc_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Slew select

  psfs_pkg::psfs_slew_e slew_raw;
  psfs_pkg::psfs_slew_e slew_cand_q;
  logic [7:0]           res_cand_q;
  logic [15:0]          filt_q;

  always_comb
  begin
    if (SLEW_PIN_OPEN_I)
      slew_raw = psfs_pkg::SLEW_OPEN;
    else if (SLEW_PIN_GND_I)
      slew_raw = psfs_pkg::SLEW_GND;
    else
      slew_raw = psfs_pkg::SLEW_RES;
  end

  // heavy filter: new setting must hold still for the whole window
  always_ff @(posedge MCLK_I or posedge SYS_RST_I)
  begin
    if (SYS_RST_I)
    begin
      slew_cand_q <= psfs_pkg::SLEW_GND;
      res_cand_q  <= 8'h00;
      filt_q      <= 16'h0000;
      slew_src_q  <= psfs_pkg::SLEW_OPEN;
      SLEW_RATE_O <= 8'(`PSFS_SLEW_MIN_VNS);
    end
    else if (rail_tie_q)
    begin
      slew_src_q  <= psfs_pkg::SLEW_RAIL;
      SLEW_RATE_O <= 8'(`PSFS_SLEW_RAIL_VNS);
    end
    else if (!boot_q)
    begin
      if (slew_raw != slew_cand_q || SLEW_RES_VNS_I != res_cand_q)
      begin
        slew_cand_q <= slew_raw;
        res_cand_q  <= SLEW_RES_VNS_I;
        filt_q      <= 16'h0000;
      end
      else if (filt_q < 16'(SLEW_FILT_CYC))
        filt_q <= filt_q + 16'h0001;
      else
      begin
        slew_src_q <= slew_cand_q;
        if (slew_cand_q == psfs_pkg::SLEW_GND)
          SLEW_RATE_O <= 8'(`PSFS_SLEW_GND_VNS);
        else if (slew_cand_q == psfs_pkg::SLEW_RES)
          SLEW_RATE_O <= clamp_slew(res_cand_q);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power stage control

  logic                 start_q;
  psfs_pkg::psfs_gate_e gate_mode;

  // Start-up ends once the series switch is on; lockout restarts it
  always_ff @(posedge MCLK_I or posedge SYS_RST_I)
  begin
    if (SYS_RST_I)
      start_q <= 1'b1;
    else if (SUPPLY_LOCKOUT_I)
      start_q <= 1'b1;
    else if (SERIES_SW_ON_I)
      start_q <= 1'b0;
  end

  // protection never looks at the report pins; the bus reaches it only through the short latch clear
  always_comb
  begin
    if (SUPPLY_LOCKOUT_I || start_q || drv_ot_q || sc_q)
      gate_mode = psfs_pkg::GATE_OFF;
    else if (sw_ot_q)
      gate_mode = psfs_pkg::GATE_HOT_DE;
    else
      gate_mode = psfs_pkg::GATE_FOLLOW;
  end

  always_ff @(posedge MCLK_I or posedge SYS_RST_I)
  begin
    if (SYS_RST_I)
    begin
      GATE_ON_O     <= 1'b0;
      HOT_DE_EN_O   <= 1'b0;
      AUX_REG_EN_O  <= 1'b0;
      NEG_RAIL_EN_O <= 1'b0;
    end
    else
    begin
      GATE_ON_O     <= (gate_mode == psfs_pkg::GATE_FOLLOW) & SWITCH_CMD_I & ~oc_q
                       & ~OC_DETECT_I;
      HOT_DE_EN_O   <= (gate_mode == psfs_pkg::GATE_HOT_DE);
      AUX_REG_EN_O  <= ~drv_ot_q & ~SUPPLY_LOCKOUT_I;
      NEG_RAIL_EN_O <= ~drv_ot_q & ~SUPPLY_LOCKOUT_I;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fault report

  logic fault_low;
  logic flag_low;

  always_comb
  begin
    fault_low = sw_ot_q | drv_ot_q | SUPPLY_LOCKOUT_I | start_q | sc_q
                | (slew_src_q == psfs_pkg::SLEW_OPEN);
    flag_low  = oc_q | sc_q;
    if (combined_q)
      fault_low = fault_low | oc_q;
  end

  always_ff @(posedge MCLK_I or posedge SYS_RST_I)
  begin
    if (SYS_RST_I)
    begin
      FAULT_N_O    <= 1'b0;
      OC_FLAG_N_O  <= 1'b1;
      OC_FLAG_OE_O <= 1'b0;
      fault_q      <= '0;
    end
    else
    begin
      FAULT_N_O    <= ~fault_low;
      OC_FLAG_N_O  <= ~flag_low;
      OC_FLAG_OE_O <= ~boot_q & ~combined_q;
      fault_q      <= '{startup: start_q, slew_open: slew_src_q == psfs_pkg::SLEW_OPEN,
                        lockout: SUPPLY_LOCKOUT_I, drv_ot: drv_ot_q, sw_ot: sw_ot_q,
                        overcurrent: oc_q, short_circ: sc_q, combined: combined_q};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Thermal PWM

  logic [15:0] pwm_cnt_q;
  logic [15:0] pwm_thr_q;

  always_ff @(posedge MCLK_I or posedge SYS_RST_I)
  begin
    if (SYS_RST_I)
    begin
      pwm_cnt_q  <= 16'h0000;
      pwm_thr_q  <= 16'h0000;
      duty_q     <= 10'h000;
      TEMP_PWM_O <= 1'b0;
    end
    else
    begin
      if (pwm_cnt_q == 16'(PWM_PERIOD_CYC - 1))
      begin
        pwm_cnt_q <= 16'h0000;
        duty_q    <= duty_pm(DIE_TEMP_C_I);
        pwm_thr_q <= 16'((int'(duty_pm(DIE_TEMP_C_I)) * PWM_PERIOD_CYC)
                         / `PSFS_DUTY_FULL_PM);
      end
      else
        pwm_cnt_q <= pwm_cnt_q + 16'h0001;
      if (sw_ot_q || drv_ot_q)
        TEMP_PWM_O <= 1'b1;
      else
        TEMP_PWM_O <= pwm_en_q & (pwm_cnt_q < pwm_thr_q);
    end
  end

endmodule
